/* File: hw/bscc_pkg.sv */
// shared constants and types of the boundary-scan cell chain
package bscc_pkg;

   localparam int IO_PINS    = 160;
   localparam int IN_PINS    = 4;
   localparam int MC_CELLS   = 256;
   localparam int CAP_STAGES = 3;
   localparam int UPD_PIN    = 2;
   localparam int UPD_NONE   = 0;
   localparam int ALL_CELLS  = IO_PINS + IN_PINS + MC_CELLS;
   localparam int CHAIN_LEN  = ALL_CELLS * CAP_STAGES;

   localparam int IR_W   = 4;
   localparam int ID_W   = 32;
   localparam int SYNC_W = 2;

   localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
   localparam logic [IR_W-1:0] IR_IDCODE  = 4'h2;
   localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_RESET   = IR_IDCODE;

   // arbitrary neutral identification value, bit 0 set as required
   localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0ABC_D001;

   typedef enum logic [15:0] {
      TAP_RESET   = 16'h0001,
      TAP_IDLE    = 16'h0002,
      TAP_SEL_DR  = 16'h0004,
      TAP_CAP_DR  = 16'h0008,
      TAP_SH_DR   = 16'h0010,
      TAP_EX1_DR  = 16'h0020,
      TAP_PAU_DR  = 16'h0040,
      TAP_EX2_DR  = 16'h0080,
      TAP_UPD_DR  = 16'h0100,
      TAP_SEL_IR  = 16'h0200,
      TAP_CAP_IR  = 16'h0400,
      TAP_SH_IR   = 16'h0800,
      TAP_EX1_IR  = 16'h1000,
      TAP_PAU_IR  = 16'h2000,
      TAP_EX2_IR  = 16'h4000,
      TAP_UPD_IR  = 16'h8000
   } bscc_tap_e;

endpackage

/* File: hw/bscc_scan_cell.sv */
// one scan_cell: three capture/shift stages, up to two update stages
`timescale 1ns/10ps
module bscc_scan_cell
   import bscc_pkg::*;
#(
   parameter int NUPD = UPD_PIN
) (
   input  wire logic                  tck,
   input  wire logic                  rst_n,
   input  wire logic                  captureEn,
   input  wire logic                  shiftEn,
   input  wire logic                  updateEn,
   input  wire logic                  scanIn,
   input  wire logic [CAP_STAGES-1:0] liveIn,
   output logic                       scanOut,
   output logic [1:0]                 updOut
);

   logic [CAP_STAGES-1:0] stage_r;

   // capture on rising edge, shift through capture stages only
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         stage_r <= '0;
      end else if (captureEn) begin
         stage_r <= liveIn;
      end else if (shiftEn) begin
         stage_r <= {stage_r[CAP_STAGES-2:0], scanIn};
      end
   end

   assign scanOut = stage_r[CAP_STAGES-1];

   generate
      if (NUPD == UPD_PIN) begin : g_upd
         logic [1:0] upd_r;
         // update stages sit off the shift path, loaded on falling edge
         always_ff @(negedge tck or negedge rst_n) begin
            if (!rst_n) begin
               upd_r <= '0;
            end else if (updateEn) begin
               upd_r <= stage_r[2:1];
            end
         end
         assign updOut = upd_r;
      end else begin : g_noupd
         assign updOut = '0;
      end
   endgenerate

endmodule

/* File: hw/bscc_top.sv */
// boundary-scan chain with its TAP controller and pin muxing
`timescale 1ns/10ps
module bscc_top
   import bscc_pkg::*;
#(
   parameter logic [ID_W-1:0] ID_VALUE = ID_DEFAULT
) (
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                tck,
   input  wire logic                tms,
   input  wire logic                tdi,
   output logic                     tdo,
   output logic                     tdoOeN,
   input  wire logic [IO_PINS-1:0]  ioIn,
   output logic [IO_PINS-1:0]       ioOut,
   output logic [IO_PINS-1:0]       ioOeN,
   input  wire logic [IN_PINS-1:0]  dinIn,
   input  wire logic [IO_PINS-1:0]  coreOut,
   input  wire logic [IO_PINS-1:0]  coreOe,
   input  wire logic [MC_CELLS-1:0] mcOut,
   input  wire logic [MC_CELLS-1:0] mcFb,
   input  wire logic [MC_CELLS-1:0] mcOe
);

   localparam int TCK_SYNC = 3 * IO_PINS + IN_PINS + 3 * MC_CELLS;
   localparam int CLK_SYNC = 2 * IO_PINS + 1;

   bscc_tap_e        tap_r;
   bscc_tap_e        tap_nxt;
   logic [IR_W-1:0]  irShift_r;
   logic [IR_W-1:0]  instr_r;
   logic [ID_W-1:0]  idShift_r;
   logic             bypass_r;
   logic             tdo_r;
   logic             tdoOeN_r;
   logic             extestLvl_r;
   logic             bsSel;
   logic             cellCap;
   logic             cellShift;
   logic             cellUpd;
   logic             drBit;
   logic [CHAIN_LEN/CAP_STAGES:0] chain;
   logic [IO_PINS-1:0] updOutV;
   logic [IO_PINS-1:0] updOeV;

   // TAP next state from TMS
   function automatic bscc_tap_e tapNext(input bscc_tap_e s,
                                         input logic m);
      case (s)
         TAP_RESET:  tapNext = m ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tapNext = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tapNext = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tapNext = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tapNext = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tapNext = m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tapNext = m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tapNext = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tapNext = m ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tapNext = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tapNext = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tapNext = m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tapNext = m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tapNext = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
         default:    tapNext = TAP_RESET;
      endcase
   endfunction

   assign tap_nxt = tapNext(tap_r, tms);

   // power-up reset is the only TAP reset besides TMS held high
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         tap_r <= TAP_RESET;
      end else begin
         tap_r <= tap_nxt;
      end
   end

   // instruction shift register
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         irShift_r <= IR_CAPTURE;
      end else if (tap_r == TAP_CAP_IR) begin
         irShift_r <= IR_CAPTURE;
      end else if (tap_r == TAP_SH_IR) begin
         irShift_r <= {tdi, irShift_r[IR_W-1:1]};
      end
   end

   // instruction latched on falling edge
   always_ff @(negedge tck or negedge rst_n) begin
      if (!rst_n) begin
         instr_r <= IR_RESET;
      end else if (tap_r == TAP_RESET) begin
         instr_r <= IR_RESET;
      end else if (tap_r == TAP_UPD_IR) begin
         instr_r <= irShift_r;
      end
   end

   // boundary chain used by sample/preload and extest only
   assign bsSel     = (instr_r == IR_EXTEST) || (instr_r == IR_SAMPLE);
   assign cellCap   = bsSel && (tap_r == TAP_CAP_DR);
   assign cellShift = bsSel && (tap_r == TAP_SH_DR);
   assign cellUpd   = bsSel && (tap_r == TAP_UPD_DR);

   // identification register
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         idShift_r <= '0;
      end else if (tap_r == TAP_CAP_DR) begin
         idShift_r <= ID_VALUE;
      end else if (tap_r == TAP_SH_DR) begin
         idShift_r <= {tdi, idShift_r[ID_W-1:1]};
      end
   end

   // bypass register
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         bypass_r <= 1'b0;
      end else if (tap_r == TAP_CAP_DR) begin
         bypass_r <= 1'b0;
      end else if (tap_r == TAP_SH_DR) begin
         bypass_r <= tdi;
      end
   end

   // live signals into the tck domain, two stages each
   logic [TCK_SYNC-1:0] tSync1_r;
   logic [TCK_SYNC-1:0] tSync2_r;
   logic [IO_PINS-1:0]  sIoIn;
   logic [IO_PINS-1:0]  sCoreOut;
   logic [IO_PINS-1:0]  sCoreOe;
   logic [IN_PINS-1:0]  sDinIn;
   logic [MC_CELLS-1:0] sMcOut;
   logic [MC_CELLS-1:0] sMcFb;
   logic [MC_CELLS-1:0] sMcOe;

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         tSync1_r <= '0;
         tSync2_r <= '0;
      end else begin
         tSync1_r <= {ioIn, coreOut, coreOe, dinIn, mcOut, mcFb, mcOe};
         tSync2_r <= tSync1_r;
      end
   end

   assign {sIoIn, sCoreOut, sCoreOe, sDinIn, sMcOut, sMcFb, sMcOe}
      = tSync2_r;

   // one chain through every cell; TDI enters at cell 0
   assign chain[0] = tdi;

   genvar gi;
   generate
      // I/O pin cells: pin level, drive value, drive enable
      for (gi = 0; gi < IO_PINS; gi++) begin : g_io
         bscc_scan_cell #(.NUPD(UPD_PIN)) u_cell (
            .tck       (tck),
            .rst_n     (rst_n),
            .captureEn (cellCap),
            .shiftEn   (cellShift),
            .updateEn  (cellUpd),
            .scanIn    (chain[gi]),
            .liveIn    ({sCoreOe[gi], sCoreOut[gi], sIoIn[gi]}),
            .scanOut   (chain[gi+1]),
            .updOut    ({updOeV[gi], updOutV[gi]})
         );
      end
      // dedicated input pin cells: variant without update stages, nothing to drive
      for (gi = 0; gi < IN_PINS; gi++) begin : g_in
         bscc_scan_cell #(.NUPD(UPD_NONE)) u_cell (
            .tck       (tck),
            .rst_n     (rst_n),
            .captureEn (cellCap),
            .shiftEn   (cellShift),
            .updateEn  (cellUpd),
            .scanIn    (chain[IO_PINS+gi]),
            .liveIn    ({2'b00, sDinIn[gi]}),
            .scanOut   (chain[IO_PINS+gi+1]),
            .updOut    ()
         );
      end
      // macrocell variant: output, feedback, enable
      for (gi = 0; gi < MC_CELLS; gi++) begin : g_mc
         bscc_scan_cell #(.NUPD(UPD_NONE)) u_cell (
            .tck       (tck),
            .rst_n     (rst_n),
            .captureEn (cellCap),
            .shiftEn   (cellShift),
            .updateEn  (cellUpd),
            .scanIn    (chain[IO_PINS+IN_PINS+gi]),
            .liveIn    ({sMcOe[gi], sMcFb[gi], sMcOut[gi]}),
            .scanOut   (chain[IO_PINS+IN_PINS+gi+1]),
            .updOut    ()
         );
      end
   endgenerate

   // data register selected by the instruction
   always_comb begin
      if (bsSel) begin
         drBit = chain[ALL_CELLS];
      end else if (instr_r == IR_IDCODE) begin
         drBit = idShift_r[0];
      end else begin
         drBit = bypass_r;
      end
   end

   // TDO changes on the falling edge, floats outside shift states
   always_ff @(negedge tck or negedge rst_n) begin
      if (!rst_n) begin
         tdo_r    <= 1'b0;
         tdoOeN_r <= 1'b1;
      end else begin
         tdo_r    <= (tap_r == TAP_SH_IR) ? irShift_r[0] : drBit;
         tdoOeN_r <= !((tap_r == TAP_SH_IR) || (tap_r == TAP_SH_DR));
      end
   end

   assign tdo    = tdo_r;
   assign tdoOeN = tdoOeN_r;

   // extest level, stable between instruction updates
   always_ff @(negedge tck or negedge rst_n) begin
      if (!rst_n) begin
         extestLvl_r <= 1'b0;
      end else begin
         extestLvl_r <= (instr_r == IR_EXTEST);
      end
   end

   // update levels into the system clock domain
   logic [CLK_SYNC-1:0] cSync1_r;
   logic [CLK_SYNC-1:0] cSync2_r;
   logic [IO_PINS-1:0]  ioOut_r;
   logic [IO_PINS-1:0]  ioOeN_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cSync1_r <= '0;
         cSync2_r <= '0;
      end else begin
         cSync1_r <= {extestLvl_r, updOeV, updOutV};
         cSync2_r <= cSync1_r;
      end
   end

   // pin drive: update stages in extest, core logic otherwise
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ioOut_r <= '0;
         ioOeN_r <= '1;
      end else if (cSync2_r[CLK_SYNC-1]) begin
         ioOut_r <= cSync2_r[IO_PINS-1:0];
         ioOeN_r <= ~cSync2_r[2*IO_PINS-1:IO_PINS];
      end else begin
         ioOut_r <= coreOut;
         ioOeN_r <= ~coreOe;
      end
   end

   assign ioOut = ioOut_r;
   assign ioOeN = ioOeN_r;

endmodule

/* File: verification/bscc_properties.sv */
// concurrent checks on the scan chain top-level ports
`timescale 1ns/10ps
module bscc_properties
   import bscc_pkg::*;
(
   input wire logic               clock,
   input wire logic               rst_n,
   input wire logic               tck,
   input wire logic               tms,
   input wire logic               tdo,
   input wire logic               tdoOeN,
   input wire logic [IO_PINS-1:0] ioOut,
   input wire logic [IO_PINS-1:0] ioOeN,
   input wire logic [IO_PINS-1:0] coreOut,
   input wire logic [IO_PINS-1:0] coreOe
);
   logic [1:0] tckSync_r;
   logic [3:0] quiet_r;
   logic       settled;
   assign settled = (quiet_r == 4'hF);
   // cycles of the pin clock since tck last moved
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) tckSync_r <= 2'h0;
      else tckSync_r <= {tckSync_r[0], tck};
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) quiet_r <= 4'h0;
      else if (tckSync_r[1] != tckSync_r[0]) quiet_r <= 4'h0;
      else if (!settled) quiet_r <= quiet_r + 4'h1;
   property p_oeAfterTms;
      @(posedge tck) disable iff (!rst_n) tms |=> tdoOeN;
   endproperty
   a_oeAfterTms: assert property (p_oeAfterTms)
      else $error("tdo enabled outside shift");
   property p_shiftOn;
      @(posedge tck) disable iff (!rst_n)
         tms[*5] ##1 !tms ##1 tms ##1 !tms[*2] |=> !tdoOeN;
   endproperty
   a_shiftOn: assert property (p_shiftOn)
      else $error("tdo not enabled in shift");
   property p_idFirstBit;
      @(posedge tck) disable iff (!rst_n)
         tms[*5] ##1 !tms ##1 tms ##1 !tms[*2] |=> tdo;
   endproperty
   a_idFirstBit: assert property (p_idFirstBit)
      else $error("identification bit 0 not one");
   property p_irCapture;
      @(posedge tck) disable iff (!rst_n)
         tms[*5] ##1 !tms ##1 tms[*2] ##1 !tms[*2]
         |=> tdo ##1 ($past(tms) || !tdo);
   endproperty
   a_irCapture: assert property (p_irCapture)
      else $error("instruction capture value wrong");
   property p_outFollow;
      @(posedge clock) disable iff (!rst_n)
         settled && $changed(ioOut) |-> ioOut == $past(coreOut);
   endproperty
   a_outFollow: assert property (p_outFollow)
      else $error("pin value not from core");
   property p_oeFollow;
      @(posedge clock) disable iff (!rst_n)
         settled && $changed(ioOeN) |-> ioOeN == ~$past(coreOe);
   endproperty
   a_oeFollow: assert property (p_oeFollow)
      else $error("pin enable not from core");
   property p_outHold;
      @(posedge clock) disable iff (!rst_n)
         settled && $stable(coreOut) |=> $stable(ioOut);
   endproperty
   a_outHold: assert property (p_outHold)
      else $error("pin value moved without cause");
   property p_tdoHold;
      @(posedge clock) disable iff (!rst_n)
         settled |-> $stable(tdo) && $stable(tdoOeN);
   endproperty
   a_tdoHold: assert property (p_tdoHold)
      else $error("tdo moved with tck still");
endmodule

/* File: verification/bscc_tester.sv */
// jtag test master model for the scan port
`timescale 1ns/10ps
module bscc_tester
   import bscc_pkg::*;
(
   output logic     tck,
   output logic     tms,
   output logic     tdi,
   input wire logic tdo,
   input wire logic tdoOeN
);
   logic run;
   initial begin
      run = 1'b0;
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      // tck stands low outside frames
      forever begin
         #3;
         tck = run ? ~tck : 1'b0;
      end
   end
   task automatic step(input logic m, input logic d, output logic q);
      @(negedge tck);
      #1;
      tms = m;
      tdi = d;
      @(posedge tck);
      // a released line reads as the inverse of the last bit
      q = tdoOeN ? ~tdo : tdo;
   endtask
   task automatic tlr;
      logic q;
      run = 1'b1;
      repeat (5) step(1'b1, 1'b1, q);
   endtask
   task automatic scan(input logic ir, input int n,
                       input logic [CHAIN_LEN-1:0] din,
                       output logic [CHAIN_LEN-1:0] dout);
      logic q;
      dout = '0;
      run = 1'b1;
      step(1'b0, 1'b1, q);
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      run = 1'b0;
   endtask
endmodule

/* File: verification/bscc_top_test.sv */
// self-checking bench for the boundary-scan chain
`timescale 1ns/10ps
module bscc_top_test
   import bscc_pkg::*;
();
   localparam int W = CHAIN_LEN;
   logic                clock, rst_n, tck, tms, tdi, tdo, tdoOeN;
   logic [IO_PINS-1:0]  ioIn = '0, coreOut = '0, coreOe = '0;
   logic [IO_PINS-1:0]  ioOut, ioOeN, pOut, pOe;
   logic [IN_PINS-1:0]  dinIn = '0;
   logic [MC_CELLS-1:0] mcOut = '0, mcFb = '0, mcOe = '0;
   logic [W-1:0]        dout;
   int                  failCount = 0;
   int                  samplesChecked = 0;
   bscc_top bscc_top_inst (.clock, .rst_n, .tck, .tms, .tdi, .tdo,
      .tdoOeN, .ioIn, .ioOut, .ioOeN, .dinIn, .coreOut, .coreOe,
      .mcOut, .mcFb, .mcOe);
   bscc_tester bscc_tester_inst (.tck, .tms, .tdi, .tdo, .tdoOeN);
   task automatic chk(input string what, input logic [W-1:0] e, g);
      samplesChecked++;
      if (g !== e) begin
         failCount++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic pins(input logic [IO_PINS-1:0] o, oeN);
      repeat (20) @(posedge clock);
      #1;
      chk("ioOut", W'(o), W'(ioOut));
      chk("ioOeN", W'(oeN), W'(ioOeN));
   endtask
   task automatic test_idcode;
      // no tms reset first: power-up must already select the id
      bscc_tester_inst.scan(1'b0, ID_W, '1, dout);
      chk("idPwr", W'(ID_DEFAULT), W'(dout[ID_W-1:0]));
      bscc_tester_inst.tlr;
      bscc_tester_inst.scan(1'b0, ID_W, '1, dout);
      chk("id", W'(ID_DEFAULT), W'(dout[ID_W-1:0]));
   endtask
   task automatic test_bypass;
      logic [3:0] code [2];
      code = '{IR_BYPASS, 4'h7};
      foreach (code[i]) begin
         bscc_tester_inst.tlr;
         bscc_tester_inst.scan(1'b1, IR_W, W'(code[i]), dout);
         chk("ir", W'(IR_CAPTURE), W'(dout[IR_W-1:0]));
         bscc_tester_inst.scan(1'b0, 8, W'(8'hA5), dout);
         chk("byp", W'({7'h25, 1'b0}), W'(dout[7:0]));
      end
   endtask
   task automatic test_sample;
      logic [W-1:0] cap, pre;
      @(posedge clock);
      #1;
      ioIn = {5{32'hC3A5_0F96}};
      dinIn = 4'hA;
      mcOut = {8{32'h1234_5678}};
      mcFb = {8{32'h9ABC_DEF0}};
      mcOe = {8{32'h0F0F_3C3C}};
      coreOut = {5{32'h5555_AAAA}};
      coreOe = {5{32'hFF00_F0F0}};
      bscc_tester_inst.scan(1'b1, IR_W, W'(IR_SAMPLE), dout);
      cap = '0;
      pre = '0;
      for (int i = 0; i < IO_PINS; i++) begin
         cap[3*i +: 3] = {coreOe[i], coreOut[i], ioIn[i]};
         pre[3*i +: 3] = {i[1], i[0], 1'b0};
         pOut[i] = i[0];
         pOe[i] = i[1];
      end
      for (int j = 0; j < IN_PINS; j++) cap[3*(IO_PINS+j)] = dinIn[j];
      for (int m = 0; m < MC_CELLS; m++)
         cap[3*(IO_PINS+IN_PINS+m) +: 3] = {mcOe[m], mcFb[m], mcOut[m]};
      // first bit in travels farthest, first bit out is the far end
      pre = {<<{pre}};
      cap = {<<{cap}};
      bscc_tester_inst.scan(1'b0, W, pre, dout);
      chk("chain", cap, dout);
   endtask
   task automatic test_extest;
      bscc_tester_inst.scan(1'b1, IR_W, W'(IR_EXTEST), dout);
      pins(pOut, ~pOe);
      coreOut = ~coreOut;
      pins(pOut, ~pOe);
      bscc_tester_inst.scan(1'b1, IR_W, W'(IR_BYPASS), dout);
      pins(coreOut, ~coreOe);
      coreOut = ~coreOut;
      coreOe = ~coreOe;
      pins(coreOut, ~coreOe);
   endtask
   task automatic finalReport;
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      rst_n = 1'b0;
      repeat (16) @(posedge clock);
      #1;
      chk("rstOe", W'({IO_PINS{1'b1}}), W'(ioOeN));
      rst_n = 1'b1;
      test_idcode;
      test_bypass;
      test_sample;
      test_extest;
      finalReport;
   end
   initial begin
      #200000;
      failCount++;
      finalReport;
   end
endmodule
bind bscc_top bscc_properties bscc_properties_inst (.clock, .rst_n, .tck,
   .tms, .tdo, .tdoOeN, .ioOut, .ioOeN, .coreOut, .coreOe);
